// [hw/scpc_top.sv]
// configuration memory output, address counter and chain control
// assumes clock at 25 MHz, config_clock sampled as a plain pin
// What this block does
// [RL1] after power-up, hold output-enable/reset low for 1 ms, then release it
// [RL2] supply below 2.0V resets the block back to the power-up state; programmed memory is kept
// [RL3] output-enable/reset is always active low, never invertible
// [RL4] chip enable high means standby with data floating
// [RL5] enabled: count to terminal count, drive data; past it, float, chain low
// [RL6] output-enable/reset and config_clock levels during standby do not disturb standby
// [RL7] each config_clock rising edge advances the counters, one bit out
// [RL8] clock after the final bit drives chain output low and floats data
// [RL9] output-enable/reset low holds counter reset, data floats, chain high
`timescale 1ns/1ps
`default_nettype none
`include "scpc_cfg.svh"

module scpc_fifo #(
	parameter int W = `SCPC_WORD_W,
	parameter int D = `SCPC_FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int PW = $clog2(D);
	logic [W-1:0] mem_r [D];
	logic [PW-1:0] wr_r;
	logic [PW-1:0] rd_r;
	logic [PW:0] cnt_r;
	logic push;
	logic pop;

	if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
		$error("fifo depth must be a power of two, at least 2");
	end

	assign in_ready = cnt_r != (PW+1)'(D);
	assign out_valid = cnt_r != '0;
	assign out_data = mem_r[rd_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else if (flush) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push)
				wr_r <= wr_r + 1'b1;
			if (pop)
				rd_r <= rd_r + 1'b1;
			if (push && !pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop && !push)
				cnt_r <= cnt_r - 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (push)
			mem_r[wr_r] <= in_data;
	end
endmodule : scpc_fifo

module scpc_top #(
	parameter int WORD_W = `SCPC_WORD_W,
	parameter int DEPTH = `SCPC_DEPTH,
	parameter int FIFO_DEPTH = `SCPC_FIFO_DEPTH,
	parameter int POR_CYCLES = `SCPC_POR_US * `SCPC_CLK_MHZ
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire scpc_pkg::scpc_in_s pins_in,
	input wire logic prog_we,
	input wire logic [$clog2(DEPTH)-1:0] prog_addr,
	input wire logic [WORD_W-1:0] prog_data,
	output var scpc_pkg::scpc_pins_s pins_out
);
	import scpc_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam int BW = $clog2(WORD_W);
	localparam int TW = $clog2(DEPTH * WORD_W);
	localparam int CW = $clog2(POR_CYCLES + 1);
	localparam logic [TW-1:0] TERMINAL_COUNT = TW'(DEPTH * WORD_W - 1);
	localparam logic [CW-1:0] POR_LAST = CW'(POR_CYCLES - 1);
	localparam logic [BW-1:0] BIT_LAST = BW'(WORD_W - 1);

	if (WORD_W < 2 || DEPTH < 2 || POR_CYCLES < 2) begin : g_chk
		$error("word width, depth and power-up count must be at least 2");
	end

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	scpc_in_s s1_r;
	scpc_in_s s2_r;
	logic link_clk_d_r;
	logic link_rise;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= `SCPC_SYNC_RST;
			s2_r <= `SCPC_SYNC_RST;
		end else begin
			s1_r <= pins_in;
			s2_r <= s1_r;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			link_clk_d_r <= 1'b0;
		else
			link_clk_d_r <= s2_r.config_clock;
	end

	assign link_rise = s2_r.config_clock && !link_clk_d_r;

	// ----------------------------------------
	// power-up hold and brown-out
	// ----------------------------------------
	logic [CW-1:0] por_cnt_r;
	logic ready_r;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			por_cnt_r <= '0;
			ready_r <= 1'b0;
		end else if (s2_r.supply_low) begin
			por_cnt_r <= '0; // RL2
			ready_r <= 1'b0; // RL2
		end else if (por_cnt_r != POR_LAST) begin
			por_cnt_r <= por_cnt_r + 1'b1; // RL1
		end else begin
			ready_r <= 1'b1; // RL1
		end
	end

	// ----------------------------------------
	// operating state
	// ----------------------------------------
	scpc_state_e state_r;
	scpc_state_e state_nxt;
	logic run;

	always_comb begin
		case (1'b1)
			!ready_r: state_nxt = ST_PWRUP;
			s2_r.ce_n: state_nxt = ST_STANDBY; // RL4 RL6
			!s2_r.oe_reset_n: state_nxt = ST_HOLD; // RL3 RL9
			default: state_nxt = ST_RUN; // RL5
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			state_r <= ST_PWRUP;
		else
			state_r <= state_nxt;
	end

	assign run = state_r == ST_RUN;

	// ----------------------------------------
	// storage and prefetch into the fifo
	// ----------------------------------------
	logic [WORD_W-1:0] mem_r [DEPTH];
	logic [AW:0] fill_r;
	logic fill_ok;
	logic f_in_ready;
	logic f_out_valid;
	logic [WORD_W-1:0] f_out_data;
	logic pop;

	for (genvar i = 0; i < DEPTH; i++) begin : g_mem
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n)
				mem_r[i] <= '0;
			else if (prog_we && prog_addr == AW'(i))
				mem_r[i] <= prog_data;
		end
	end

	assign fill_ok = run && fill_r < (AW+1)'(DEPTH);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			fill_r <= '0;
		else if (!run)
			fill_r <= '0;
		else if (fill_ok && f_in_ready)
			fill_r <= fill_r + 1'b1;
	end

	scpc_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_fifo (
		.clock(clock),
		.rst_n(rst_n),
		.flush(!run),
		.in_valid(fill_ok),
		.in_ready(f_in_ready),
		.in_data(mem_r[fill_r[AW-1:0]]),
		.out_valid(f_out_valid),
		.out_ready(pop),
		.out_data(f_out_data)
	);

	// ----------------------------------------
	// bit shifter and address counter
	// ----------------------------------------
	logic [WORD_W-1:0] shift_r;
	logic [BW-1:0] bit_r;
	logic full_r;
	logic [TW-1:0] addr_r;
	logic done_r;
	logic adv;
	logic last;

	assign adv = run && link_rise && full_r && !done_r; // RL7
	assign last = bit_r == BIT_LAST;
	assign pop = run && f_out_valid && (!full_r || (adv && last));

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			shift_r <= '0;
			bit_r <= '0;
			full_r <= 1'b0;
		end else if (!run) begin
			bit_r <= '0;
			full_r <= 1'b0;
		end else if (pop) begin
			shift_r <= f_out_data;
			bit_r <= '0;
			full_r <= 1'b1;
		end else if (adv) begin
			shift_r <= {shift_r[WORD_W-2:0], 1'b0}; // RL7
			bit_r <= bit_r + 1'b1;
			if (last)
				full_r <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			addr_r <= '0;
			done_r <= 1'b0;
		end else if (!run) begin
			addr_r <= '0; // RL9
			done_r <= 1'b0;
		end else if (adv) begin
			if (addr_r == TERMINAL_COUNT)
				done_r <= 1'b1; // RL5 RL8
			else
				addr_r <= addr_r + 1'b1; // RL5
		end
	end

	// ----------------------------------------
	// pin drivers
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pins_out <= `SCPC_PIN_RST;
		end else begin
			pins_out.data <= shift_r[WORD_W-1];
			pins_out.data_oe <= run && full_r && !done_r; // RL4 RL5 RL9
			pins_out.chain_enable_out_n <= !(run && done_r); // RL8
			pins_out.oe_reset_o <= 1'b0;
			pins_out.oe_reset_oe <= !ready_r; // RL1
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_last_edge;
		adv && addr_r == TERMINAL_COUNT;
	endsequence
	sequence s_floated;
		!pins_out.data_oe && !pins_out.chain_enable_out_n;
	endsequence

	property p_por_hold;
		!ready_r |=> pins_out.oe_reset_oe && !pins_out.oe_reset_o;
	endproperty
	a_por_hold: assert property (p_por_hold) // RL1
		else $error("reset line not held during power-up");

	property p_por_time;
		$rose(ready_r) |-> por_cnt_r == POR_LAST;
	endproperty
	a_por_time: assert property (p_por_time) // RL1
		else $error("power-up hold ended at wrong count");

	property p_brownout;
		s2_r.supply_low |=> !ready_r ##1 state_r == ST_PWRUP ##1 addr_r == '0;
	endproperty
	a_brownout: assert property (p_brownout) // RL2
		else $error("low supply did not reset the block");

	property p_polarity;
		ready_r && !s2_r.ce_n && !s2_r.oe_reset_n |=> state_r == ST_HOLD;
	endproperty
	a_polarity: assert property (p_polarity) // RL3
		else $error("low reset input did not hold");

	property p_standby;
		state_r == ST_STANDBY |=> !pins_out.data_oe;
	endproperty
	a_standby: assert property (p_standby) // RL4
		else $error("data driven in standby");

	property p_count;
		adv && addr_r != TERMINAL_COUNT |=> addr_r == $past(addr_r) + 1'b1;
	endproperty
	a_count: assert property (p_count) // RL5
		else $error("address did not advance");

	property p_stay_standby;
		ready_r && state_r == ST_STANDBY && s2_r.ce_n
			&& !s2_r.supply_low
			|=> state_r == ST_STANDBY;
	endproperty
	a_stay_standby: assert property (p_stay_standby) // RL6
		else $error("standby left without chip enable");

	property p_bit_wrap;
		adv && last && !pop |=> !full_r && bit_r == '0;
	endproperty
	a_bit_wrap: assert property (p_bit_wrap) // RL7
		else $error("bit counter failed to wrap");

	property p_final;
		s_last_edge |=> done_r ##1 s_floated;
	endproperty
	a_final: assert property (p_final) // RL8
		else $error("chain output not low after last bit");

	property p_hold;
		state_r == ST_HOLD |=> addr_r == '0 && !pins_out.data_oe
			&& pins_out.chain_enable_out_n;
	endproperty
	a_hold: assert property (p_hold) // RL9
		else $error("counter or pins wrong while held");

endmodule : scpc_top

`default_nettype wire

// [hw/scpc_cfg.svh]
// constants for the serial configuration memory control block
// assumes inclusion by bare name from the package and the design file
`ifndef SCPC_CFG_SVH
`define SCPC_CFG_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define SCPC_CLK_MHZ 25
`define SCPC_POR_US 1000

// ----------------------------------------
// geometry
// ----------------------------------------
`define SCPC_WORD_W 8
`define SCPC_DEPTH 16
`define SCPC_FIFO_DEPTH 8

// ----------------------------------------
// reset values
// ----------------------------------------
`define SCPC_SYNC_RST 4'h0
`define SCPC_PIN_RST 5'h04

`endif

// [hw/scpc_pkg.sv]
// types shared by the configuration memory control block
// assumes scpc_cfg.svh on the include path
`include "scpc_cfg.svh"

package scpc_pkg;

	// ----------------------------------------
	// operating states
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_PWRUP,
		ST_STANDBY,
		ST_HOLD,
		ST_RUN
	} scpc_state_e;

	// ----------------------------------------
	// pins from the board, before sync
	// ----------------------------------------
	typedef struct packed {
		logic config_clock;
		logic oe_reset_n;
		logic ce_n;
		logic supply_low;
	} scpc_in_s;

	// ----------------------------------------
	// pins toward the board
	// ----------------------------------------
	typedef struct packed {
		logic data;
		logic data_oe;
		logic chain_enable_out_n;
		logic oe_reset_o;
		logic oe_reset_oe;
	} scpc_pins_s;

endpackage : scpc_pkg

// [verif/scpc_fpga_model.sv]
// fpga-side model: config_clock pulses, oe/reset pull, data sampling
// assumes pins_out of scpc_top; board pull-ups resolved here
`timescale 1ns/1ps
`default_nettype none

module scpc_fpga_model
	import scpc_pkg::*;
(
	input wire scpc_pkg::scpc_pins_s pins_out,
	input wire logic oe_pull_low,
	output logic config_clock,
	output logic oe_wire
);
	logic data_wire;

	initial config_clock = 1'b0;

	// ----------------------------------------
	// wire resolution
	// ----------------------------------------
	// open drain with pull-up, either party may pull low
	assign oe_wire = pins_out.oe_reset_oe ? pins_out.oe_reset_o : !oe_pull_low;
	// din pull-up when floated
	assign data_wire = pins_out.data_oe ? pins_out.data : 1'b1;

	// ----------------------------------------
	// one link clock period, sampled before the rise
	// ----------------------------------------
	task automatic clk_pulse(output logic b);
		#140;
		b = data_wire;
		#20 config_clock = 1'b1;
		#160 config_clock = 1'b0;
	endtask : clk_pulse

endmodule : scpc_fpga_model

`default_nettype wire

// [verif/tb_scpc_top.sv]
// bench for the configuration memory control block
// assumes scpc_pkg, scpc_top, scpc_fifo and scpc_fpga_model compiled
`timescale 1ns/1ps
`default_nettype none

module tb_scpc_top;
	import scpc_pkg::*;
	localparam int POR = 20;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic ce_n = 1'b1;
	logic supply_low = 1'b0;
	logic oe_pull_low = 1'b0;
	logic prog_we = 1'b0;
	logic [3:0] prog_addr = 4'h0;
	logic [7:0] prog_data = 8'h00;
	logic cfg_clk, oe_wire;
	scpc_pins_s pins_out;
	int err_total = 0;
	int check_count = 0;
	int cyc = 0;

	always #20 clock = ~clock;

	scpc_top #(.POR_CYCLES(POR)) dut (.clock(clock), .rst_n(rst_n),
		.pins_in({cfg_clk, oe_wire, ce_n, supply_low}), .prog_we(prog_we),
		.prog_addr(prog_addr), .prog_data(prog_data), .pins_out(pins_out));
	scpc_fpga_model m (.pins_out(pins_out), .oe_pull_low(oe_pull_low),
		.config_clock(cfg_clk), .oe_wire(oe_wire));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic exp_bit(input int i);
		logic [7:0] w;
		w = {4'(i / 8), ~4'(i / 8)};
		return w[7 - i % 8];
	endfunction : exp_bit

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim

	task automatic cycles(input int n);
		repeat (n) @(posedge clock);
	endtask : cycles

	task automatic rd_bits(input int n, input int first);
		logic b;
		// keep link edges off the system clock edge
		#10;
		for (int i = 0; i < n; i++) begin
			m.clk_pulse(b);
			check({7'h00, b}, {7'h00, exp_bit(first + i)});
		end
		@(posedge clock);
	endtask : rd_bits

	task automatic rd_word(input logic [7:0] w);
		logic b;
		#10;
		for (int i = 7; i >= 0; i--) begin
			m.clk_pulse(b);
			check({7'h00, b}, {7'h00, w[i]});
		end
		@(posedge clock);
	endtask : rd_word

	task automatic wait_ready(output int n);
		n = 0;
		while (pins_out.oe_reset_oe !== 1'b0 && n < 200) begin
			@(posedge clock);
			n++;
		end
	endtask : wait_ready

	function automatic logic [7:0] outs;
		return {6'h00, pins_out.data_oe, pins_out.chain_enable_out_n};
	endfunction : outs

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_por;
		int n;
		cycles(2);
		check({7'h00, oe_wire}, 8'h00);
		wait_ready(n);
		check(8'(n >= POR - 2 && n <= POR + 3), 8'h01);
		check({7'h00, oe_wire}, 8'h01);
	endtask : t_por

	task automatic t_read_all;
		logic b;
		logic [7:0] o;
		ce_n <= 1'b0;
		cycles(10);
		rd_bits(128, 0);
		cycles(8);
		check(outs(), 8'h00);
		#10;
		m.clk_pulse(b);
		cycles(8);
		o = outs();
		check({5'h00, b, o[1:0]}, 8'h04);
	endtask : t_read_all

	task automatic t_hold;
		logic b;
		oe_pull_low <= 1'b1;
		cycles(6);
		check(outs(), 8'h01);
		#10;
		m.clk_pulse(b);
		@(posedge clock);
		check(outs(), 8'h01);
		oe_pull_low <= 1'b0;
		cycles(10);
		rd_bits(8, 0);
	endtask : t_hold

	task automatic t_standby;
		rd_bits(3, 8);
		ce_n <= 1'b1;
		cycles(6);
		check(outs(), 8'h01);
		oe_pull_low <= 1'b1;
		cycles(6);
		check(outs(), 8'h01);
		oe_pull_low <= 1'b0;
		ce_n <= 1'b0;
		cycles(10);
		rd_bits(8, 0);
	endtask : t_standby

	task automatic t_brown;
		int n;
		rd_bits(3, 8);
		supply_low <= 1'b1;
		cycles(4);
		supply_low <= 1'b0;
		cycles(4);
		check({6'h00, pins_out.oe_reset_oe, pins_out.data_oe}, 8'h02);
		wait_ready(n);
		check(8'(n >= POR - 8 && n <= POR + 4), 8'h01);
		cycles(10);
		rd_bits(8, 0);
	endtask : t_brown

	// prefetch fills the buffer; later writes reach only unfetched words
	task automatic t_prefetch;
		ce_n <= 1'b1;
		cycles(6);
		check(outs(), 8'h01);
		ce_n <= 1'b0;
		cycles(20);
		check(outs(), 8'h03);
		@(posedge clock);
		prog_we <= 1'b1;
		prog_addr <= 4'h1;
		prog_data <= 8'hC3;
		@(posedge clock);
		prog_addr <= 4'hF;
		prog_data <= 8'h3C;
		@(posedge clock);
		prog_we <= 1'b0;
		rd_bits(120, 0);
		rd_word(8'h3C);
		cycles(8);
		check(outs(), 8'h00);
	endtask : t_prefetch

	// ----------------------------------------
	// main sequence and timeout
	// ----------------------------------------
	initial begin
		cycles(12);
		rst_n <= 1'b1;
		t_por();
		for (int k = 0; k < 16; k++) begin
			@(posedge clock);
			prog_we <= 1'b1;
			prog_addr <= 4'(k);
			prog_data <= {4'(k), ~4'(k)};
		end
		@(posedge clock);
		prog_we <= 1'b0;
		t_read_all();
		t_hold();
		t_standby();
		t_brown();
		t_prefetch();
		end_sim();
	end

	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			end_sim();
		end
	end

endmodule : tb_scpc_top

`default_nettype wire
